// file: fpur_iu_model.sv
// integer unit model that issues operations to the floating-point state
`timescale 1ns/1ns
`default_nettype none
module fpur_iu_model
  import fpur_pkg::*;
(
  input  wire logic    clk,
  output logic         op_start,
  output fpur_kind_e   op_start_kind,
  output logic [31:0]  op_addr,
  output logic         op_done,
  output fpur_result_s op_result
);
  initial begin
    op_start = 1'b0;
    op_start_kind = kind_quiet;
    op_addr = 32'h0;
    op_done = 1'b0;
    op_result = '0;
  end

  // start for one cycle, then done gap+1 cycles after start; idle fields show scrambled values
  task automatic issue(input fpur_kind_e k, input logic [31:0] a, input fpur_result_s r, input int gap);
    @(posedge clk);
    op_start <= 1'b1;
    op_start_kind <= k;
    op_addr <= a;
    @(posedge clk);
    op_start <= 1'b0;
    op_start_kind <= fpur_kind_e'(~k);
    op_addr <= ~a;
    repeat (gap) @(posedge clk);
    op_done <= 1'b1;
    op_result <= r;
    @(posedge clk);
    op_done <= 1'b0;
    op_result <= ~r;
  endtask : issue
endmodule : fpur_iu_model
`default_nettype wire

// file: fpur_map.svh
// field positions, reset values and conversion constants of the floating-point user state
`ifndef FPUR_MAP_SVH
`define FPUR_MAP_SVH

`define FPUR_NUM_DATA        8
`define FPUR_IDX_W           3
`define FPUR_EXT_W           80
`define FPUR_MANT_W          64
`define FPUR_EXP_W           15

`define FPUR_CTRL_USED_HI    15
`define FPUR_CTRL_ENA_HI     15
`define FPUR_CTRL_ENA_LO     8
`define FPUR_CTRL_WIDTH_HI   7
`define FPUR_CTRL_WIDTH_LO   6
`define FPUR_CTRL_RND_HI     5
`define FPUR_CTRL_RND_LO     4
`define FPUR_CTRL_RESET      32'h0000_0000

`define FPUR_STAT_CC_HI      27
`define FPUR_STAT_CC_LO      24
`define FPUR_STAT_QUOT_HI    23
`define FPUR_STAT_QUOT_LO    16
`define FPUR_STAT_EXC_HI     15
`define FPUR_STAT_EXC_LO     8
`define FPUR_STAT_ACC_HI     7
`define FPUR_STAT_ACC_LO     3
`define FPUR_STAT_RESET      32'h0000_0000
`define FPUR_IADDR_RESET     32'h0000_0000

`define FPUR_EXC_UNORD       7
`define FPUR_EXC_SIGNAL_NAN_FLAG        6
`define FPUR_EXC_BAD_OPERAND_FLAG       5
`define FPUR_EXC_OVERFLOW_FLAG        4
`define FPUR_EXC_UNDERFLOW_FLAG        3
`define FPUR_EXC_DZ          2
`define FPUR_EXC_IMPRECISE_CALC_FLAG       1
`define FPUR_EXC_IMPRECISE_INPUT_FLAG       0

`define FPUR_ACC_IOP         4
`define FPUR_ACC_OVERFLOW_FLAG        3
`define FPUR_ACC_UNDERFLOW_FLAG        2
`define FPUR_ACC_DZ          1
`define FPUR_ACC_IMPRECISE_RESULT_FLAG        0

`define FPUR_QNAN_POS        80'h7fff_ffff_ffff_ffff_ffff

`define FPUR_MANT_SGL        7'h18
`define FPUR_MANT_DBL        7'h35
`define FPUR_MANT_EXT        7'h40

`define FPUR_EXP_MAX         15'h7fff
`define FPUR_SGL_EXP_ADJ     15'h3f80
`define FPUR_SGL_DEN_EXP     15'h3f81
`define FPUR_DBL_EXP_ADJ     15'h3c00
`define FPUR_DBL_DEN_EXP     15'h3c01

`endif

// file: fpur_pkg.sv
// types of the floating-point user state block
`default_nettype none
package fpur_pkg;
  `include "fpur_map.svh"

  typedef enum logic [1:0] {
    round_nearest  = 2'h0,
    round_to_zero  = 2'h1,
    round_down_neg = 2'h2,
    round_up_pos   = 2'h3
  } fpur_round_e;

  typedef enum logic [1:0] {
    width_ext  = 2'h0,
    width_sgl  = 2'h1,
    width_dbl  = 2'h2,
    width_undf = 2'h3
  } fpur_width_e;

  typedef enum logic [1:0] {
    fmt_ext = 2'h0,
    fmt_sgl = 2'h1,
    fmt_dbl = 2'h2
  } fpur_fmt_e;

  // operation classes issued by the integer unit
  typedef enum logic [2:0] {
    kind_arith      = 3'h0,
    kind_move_in    = 3'h1,
    kind_move_out   = 3'h2,
    kind_multi_move = 3'h3,
    kind_ctrl_move  = 3'h4,
    kind_quiet      = 3'h5
  } fpur_kind_e;

  typedef enum logic [1:0] {
    sel_control = 2'h0,
    sel_status  = 2'h1,
    sel_iaddr   = 2'h2
  } fpur_sel_e;

  typedef struct packed {
    logic        sign;
    logic [14:0] exp;
    logic [63:0] mant;
  } fpur_ext_s;

  typedef struct packed {
    fpur_fmt_e   fmt;
    logic [79:0] payload;
  } fpur_in_s;

  typedef struct packed {
    fpur_kind_e  kind;
    logic [3:0]  cc;
    logic        quot_valid;
    logic [7:0]  quot;
    logic [7:0]  trap_status_byte;
  } fpur_result_s;
endpackage : fpur_pkg
`default_nettype wire

// file: fpur_regs.sv
// floating-point programmer-visible register state
//
// What this block does
// - data registers hold only extended-precision values
// - reset or null restore loads quiet NaNs
// - control bits 31..16 read zero, writes dropped
// - control is user read/write, cleared on reset
// - one trap enable bit per exception class
// - two-bit rounding mode decodes four directions
// - two-bit width field: extended, single, double
// - mantissa rounds at 24, 53 or 64 bits
// - status fully user read/write, cleared on reset
// - condition codes follow arithmetic only
// - quotient field holds until a valid quotient or a user write
// - exception byte cleared only by capable operations
// - accrued byte ORs combined exception bits
// - accrued bits sticky until write or reset
// - accrued writes never raise or hide traps
// - capture instruction address before capable operations
// - multi-moves and control moves keep instruction address
// - instruction address cleared on reset or restore
`timescale 1ns/1ns
`default_nettype none
`include "fpur_map.svh"

module fpur_regs
  import fpur_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         null_restore,
  input  wire logic         user_wr,
  input  wire fpur_sel_e    user_sel,
  input  wire logic [31:0]  user_wdata,
  output logic      [31:0]  user_rdata,
  input  wire logic         data_wr,
  input  wire logic [2:0]   data_wr_idx,
  input  wire fpur_in_s     data_wr_src,
  input  wire logic [2:0]   data_rd_idx,
  output fpur_ext_s         data_rd,
  input  wire logic         op_start,
  input  wire fpur_kind_e   op_start_kind,
  input  wire logic [31:0]  op_addr,
  input  wire logic         op_done,
  input  wire fpur_result_s op_result,
  output fpur_round_e       round_mode,
  output fpur_width_e       round_width,
  output logic      [6:0]   round_mant_bits,
  output logic      [7:0]   trap_enable,
  output logic              trap_req
);

  fpur_ext_s   data_r [`FPUR_NUM_DATA];
  logic [15:0] ctrl_r;
  logic [31:0] status_r;
  logic [31:0] status_nxt;
  logic [31:0] iaddr_r;
  logic [31:0] user_rdata_r;
  fpur_ext_s   data_rd_r;
  logic        trap_req_r;

  // extended-precision image of an incoming operand
  function automatic fpur_ext_s to_extended(input fpur_in_s src);
    fpur_ext_s   res;
    logic [7:0]  se;
    logic [22:0] sf;
    logic [10:0] de;
    logic [51:0] df;
    res = src.payload;
    se  = src.payload[30:23];
    sf  = src.payload[22:0];
    de  = src.payload[62:52];
    df  = src.payload[51:0];
    unique case (src.fmt)
      fmt_sgl: begin
        res.sign = src.payload[31];
        if (se == 8'hff) begin
          res.exp  = `FPUR_EXP_MAX;
          res.mant = {1'b1, sf, 40'h0};
        end else if (se == 8'h00 && sf == 23'h0) begin
          res.exp  = 15'h0;
          res.mant = 64'h0;
        end else if (se == 8'h00) begin
          res.exp  = `FPUR_SGL_DEN_EXP;
          res.mant = {1'b0, sf, 40'h0};
        end else begin
          res.exp  = `FPUR_SGL_EXP_ADJ + {7'h0, se};
          res.mant = {1'b1, sf, 40'h0};
        end
      end
      fmt_dbl: begin
        res.sign = src.payload[63];
        if (de == 11'h7ff) begin
          res.exp  = `FPUR_EXP_MAX;
          res.mant = {1'b1, df, 11'h0};
        end else if (de == 11'h000 && df == 52'h0) begin
          res.exp  = 15'h0;
          res.mant = 64'h0;
        end else if (de == 11'h000) begin
          res.exp  = `FPUR_DBL_DEN_EXP;
          res.mant = {1'b0, df, 11'h0};
        end else begin
          res.exp  = `FPUR_DBL_EXP_ADJ + {4'h0, de};
          res.mant = {1'b1, df, 11'h0};
        end
      end
      default: res = src.payload;
    endcase
    return res;
  endfunction : to_extended

  // decoding of user selects, operation classes, exception inputs and control fields
  wire fpur_ext_s  wr_ext      = to_extended(data_wr_src);
  wire logic       ctrl_wr     = user_wr && user_sel == sel_control;
  wire logic       status_wr   = user_wr && user_sel == sel_status;
  wire logic       iaddr_wr    = user_wr && user_sel == sel_iaddr;
  wire logic       start_cap   = op_start && (op_start_kind == kind_arith || op_start_kind == kind_move_in ||
                                              op_start_kind == kind_move_out);
  wire logic       done_cap    = op_done && (op_result.kind == kind_arith || op_result.kind == kind_move_in ||
                                             op_result.kind == kind_move_out);
  wire logic       done_arith  = op_done && op_result.kind == kind_arith;
  wire logic [7:0] exc_in      = op_result.trap_status_byte;
  wire logic [4:0] acc_in      = {exc_in[`FPUR_EXC_SIGNAL_NAN_FLAG] | exc_in[`FPUR_EXC_BAD_OPERAND_FLAG],
                                  exc_in[`FPUR_EXC_OVERFLOW_FLAG],
                                  exc_in[`FPUR_EXC_UNDERFLOW_FLAG] & exc_in[`FPUR_EXC_IMPRECISE_CALC_FLAG],
                                  exc_in[`FPUR_EXC_DZ],
                                  exc_in[`FPUR_EXC_IMPRECISE_INPUT_FLAG] | exc_in[`FPUR_EXC_IMPRECISE_CALC_FLAG] |
                                  exc_in[`FPUR_EXC_OVERFLOW_FLAG]};

  assign round_mode  = fpur_round_e'(ctrl_r[`FPUR_CTRL_RND_HI:`FPUR_CTRL_RND_LO]);
  assign round_width = fpur_width_e'(ctrl_r[`FPUR_CTRL_WIDTH_HI:`FPUR_CTRL_WIDTH_LO]);
  assign trap_enable = ctrl_r[`FPUR_CTRL_ENA_HI:`FPUR_CTRL_ENA_LO];
  // undefined width code falls back to extended rounding
  assign round_mant_bits = (round_width == width_sgl) ? `FPUR_MANT_SGL :
                           (round_width == width_dbl) ? `FPUR_MANT_DBL : `FPUR_MANT_EXT;

  // status next value; hardware updates land after a user write
  always_comb begin
    status_nxt = status_r;
    if (status_wr) begin
      status_nxt = user_wdata;
    end
    if (start_cap) begin
      status_nxt[`FPUR_STAT_EXC_HI:`FPUR_STAT_EXC_LO] = 8'h00;
    end
    if (done_arith) begin
      status_nxt[`FPUR_STAT_CC_HI:`FPUR_STAT_CC_LO] = op_result.cc;
    end
    if (op_done && op_result.quot_valid) begin
      status_nxt[`FPUR_STAT_QUOT_HI:`FPUR_STAT_QUOT_LO] = op_result.quot;
    end
    if (done_cap) begin
      status_nxt[`FPUR_STAT_EXC_HI:`FPUR_STAT_EXC_LO] = exc_in;
    end
    if (done_arith) begin
      status_nxt[`FPUR_STAT_ACC_HI:`FPUR_STAT_ACC_LO] =
        status_nxt[`FPUR_STAT_ACC_HI:`FPUR_STAT_ACC_LO] | acc_in;
    end
  end

  wire logic [31:0] rd_mux = (user_sel == sel_control) ? {16'h0, ctrl_r} :
                             (user_sel == sel_status)  ? status_r : iaddr_r;

  // data registers
  wire logic [`FPUR_NUM_DATA-1:0] nan_flag;
  genvar gi;
  generate
    for (gi = 0; gi < `FPUR_NUM_DATA; gi++) begin : g_data
      assign nan_flag[gi] = data_r[gi] == `FPUR_QNAN_POS;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          data_r[gi] <= `FPUR_QNAN_POS;
        end else if (null_restore) begin
          data_r[gi] <= `FPUR_QNAN_POS;
        end else if (data_wr && data_wr_idx == 3'(gi)) begin
          data_r[gi] <= wr_ext;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= 16'(`FPUR_CTRL_RESET);
    end else if (null_restore) begin
      ctrl_r <= 16'(`FPUR_CTRL_RESET);
    end else if (ctrl_wr) begin
      ctrl_r <= user_wdata[`FPUR_CTRL_USED_HI:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= `FPUR_STAT_RESET;
    end else if (null_restore) begin
      status_r <= `FPUR_STAT_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  // capable operations and user writes load the address, a capable start winning; multi-moves and control moves leave it alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      iaddr_r <= `FPUR_IADDR_RESET;
    end else if (null_restore) begin
      iaddr_r <= `FPUR_IADDR_RESET;
    end else if (start_cap) begin
      iaddr_r <= op_addr;
    end else if (iaddr_wr) begin
      iaddr_r <= user_wdata;
    end
  end

  // trap follows the exception byte only, never the accrued byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trap_req_r <= 1'b0;
    end else begin
      trap_req_r <= !null_restore && done_cap && |(exc_in & trap_enable);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      user_rdata_r <= 32'h0;
      data_rd_r    <= '0;
    end else begin
      user_rdata_r <= rd_mux;
      data_rd_r    <= data_r[data_rd_idx];
    end
  end

  assign user_rdata = user_rdata_r;
  assign data_rd    = data_rd_r;
  assign trap_req   = trap_req_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_cap_start;
    start_cap && !null_restore;
  endsequence

  sequence s_quiet_cycle;
    !status_wr && !null_restore;
  endsequence

  sequence s_ext_store;
    data_wr && !null_restore && data_wr_src.fmt == fmt_ext;
  endsequence

  sequence s_single_two;
    data_wr && !null_restore && data_wr_src.fmt == fmt_sgl && data_wr_src.payload[30:23] == 8'h80;
  endsequence

  wire logic all_nan = &nan_flag;

  a_restore_nan: assert property (null_restore |=> all_nan)
    else $error("data registers not quiet NaN after restore");

  a_ext_store: assert property (s_ext_store |=> data_r[$past(data_wr_idx)] == $past(data_wr_src.payload))
    else $error("extended operand altered on store");

  a_single_store: assert property (s_single_two |=> data_r[$past(data_wr_idx)].exp == 15'h4000)
    else $error("single operand exponent not rebiased");

  a_ctrl_upper_zero: assert property (user_sel == sel_control |=> user_rdata[31:16] == 16'h0)
    else $error("control upper half not zero on read");

  a_ctrl_restore: assert property (null_restore |=> ctrl_r == 16'h0 && round_mode == round_nearest &&
                                   round_width == width_ext && trap_enable == 8'h00)
    else $error("control not cleared by restore");

  a_ctrl_write: assert property (ctrl_wr && !null_restore |=> ctrl_r == $past(user_wdata[15:0]))
    else $error("control write not stored");

  a_round_write: assert property (ctrl_wr && !null_restore |=>
                                  round_mode == fpur_round_e'($past(user_wdata[5:4])))
    else $error("rounding mode does not follow write");

  a_mant_single: assert property (round_width == width_sgl |-> round_mant_bits == 7'h18)
    else $error("single width not 24 mantissa bits");

  a_mant_double: assert property (round_width == width_dbl |-> round_mant_bits == 7'h35)
    else $error("double width not 53 mantissa bits");

  a_mant_extended: assert property (round_width == width_ext |-> round_mant_bits == 7'h40)
    else $error("extended width not 64 mantissa bits");

  a_trap_masked: assert property (done_cap && (exc_in & trap_enable) == 8'h00 |=> !trap_req)
    else $error("disabled exception class requested trap");

  a_status_write: assert property (status_wr && !null_restore && !start_cap && !op_done |=>
                                   status_r == $past(user_wdata))
    else $error("status write not stored");

  a_status_restore: assert property (null_restore |=> status_r == 32'h0)
    else $error("status not cleared by restore");

  a_cc_load: assert property (done_arith && !null_restore |=> status_r[27:24] == $past(op_result.cc))
    else $error("condition codes not loaded by arithmetic");

  a_cc_hold: assert property ((op_done && op_result.kind != kind_arith) and s_quiet_cycle |=>
                              $stable(status_r[27:24]))
    else $error("condition codes changed by non-arithmetic op");

  a_quot_load: assert property (op_done && op_result.quot_valid && !null_restore |=>
                                status_r[23:16] == $past(op_result.quot))
    else $error("quotient byte not loaded");

  a_quot_hold: assert property ((!(op_done && op_result.quot_valid)) and s_quiet_cycle |=>
                                $stable(status_r[23:16]))
    else $error("quotient changed without cause");

  a_exc_load: assert property (done_cap && !null_restore |=> status_r[15:8] == $past(exc_in))
    else $error("exception byte not loaded at end");

  a_exc_keep: assert property ((op_done && !done_cap && !start_cap) and s_quiet_cycle |=>
                               $stable(status_r[15:8]))
    else $error("exception byte changed by incapable op");

  a_acc_sticky: assert property (s_quiet_cycle |=>
                                 (status_r[7:3] & $past(status_r[7:3])) == $past(status_r[7:3]))
    else $error("accrued bit dropped");

  a_acc_overflow_flag: assert property (done_arith && exc_in[4] && !null_restore |=> status_r[6] && status_r[3])
    else $error("overflow not accrued as overflow and inexact");

  a_acc_iop: assert property (done_arith && (exc_in[6] || exc_in[5]) && !null_restore |=> status_r[7])
    else $error("invalid operation not accrued");

  a_acc_underflow_flag: assert property (done_arith && exc_in[3] && !exc_in[1] && !status_r[5] &&
                               !status_wr && !null_restore |=> !status_r[5])
    else $error("underflow accrued without inexact");

  a_no_write_trap: assert property (status_wr && !done_cap |=> !trap_req)
    else $error("status write requested trap");

  a_exc_cleared: assert property (s_cap_start ##0 !op_done ##0 !status_wr |=> status_r[15:8] == 8'h00)
    else $error("exception byte not cleared at start");

  a_iaddr_capture: assert property (s_cap_start |=> iaddr_r == $past(op_addr))
    else $error("instruction address not captured");

  a_iaddr_keep: assert property (!start_cap && !user_wr && !null_restore |=> $stable(iaddr_r))
    else $error("instruction address changed by move");

  a_iaddr_restore: assert property (null_restore |=> iaddr_r == 32'h0)
    else $error("instruction address not cleared by restore");

  a_trap_raise: assert property (done_cap && |(exc_in & trap_enable) && !null_restore |=>
                                 trap_req ##1 !trap_req or (done_cap && |(exc_in & trap_enable)))
    else $error("enabled exception did not request trap");

endmodule : fpur_regs

`default_nettype wire

// file: fpur_regs_bench.sv
// self-checking bench for the floating-point user state
`timescale 1ns/1ns
`default_nettype none
module fpur_regs_bench import fpur_pkg::*;;
  logic         clk, rst_n, null_restore, user_wr, data_wr, op_start, op_done, trap_req;
  fpur_sel_e    user_sel;
  logic [31:0]  user_wdata, user_rdata, op_addr, rv;
  logic [2:0]   data_wr_idx, data_rd_idx;
  fpur_in_s     data_wr_src;
  fpur_ext_s    data_rd;
  fpur_kind_e   op_start_kind;
  fpur_result_s op_result;
  fpur_round_e  round_mode;
  fpur_width_e  round_width;
  logic [6:0]   round_mant_bits;
  logic [7:0]   trap_enable;
  logic [79:0]  dv;
  int           fails, n_tests;
  localparam logic [79:0] qnan = 80'h7fff_ffff_ffff_ffff_ffff;

  fpur_regs dut (.clk(clk), .rst_n(rst_n), .null_restore(null_restore), .user_wr(user_wr),
    .user_sel(user_sel), .user_wdata(user_wdata), .user_rdata(user_rdata), .data_wr(data_wr),
    .data_wr_idx(data_wr_idx), .data_wr_src(data_wr_src), .data_rd_idx(data_rd_idx), .data_rd(data_rd),
    .op_start(op_start), .op_start_kind(op_start_kind), .op_addr(op_addr), .op_done(op_done),
    .op_result(op_result), .round_mode(round_mode), .round_width(round_width),
    .round_mant_bits(round_mant_bits), .trap_enable(trap_enable), .trap_req(trap_req));
  fpur_iu_model iu (.clk(clk), .op_start(op_start), .op_start_kind(op_start_kind), .op_addr(op_addr),
    .op_done(op_done), .op_result(op_result));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic check(input string nm, input logic [79:0] seen, input logic [79:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input fpur_sel_e s, input logic [31:0] d);
    @(posedge clk);
    user_wr <= 1'b1;
    user_sel <= s;
    user_wdata <= d;
    @(posedge clk);
    user_wr <= 1'b0;
  endtask : wr

  task automatic rd(input fpur_sel_e s, output logic [31:0] v);
    @(posedge clk);
    user_sel <= s;
    @(posedge clk);
    #1 v = user_rdata;
  endtask : rd

  task automatic dwr(input logic [2:0] i, input fpur_in_s src);
    @(posedge clk);
    data_wr <= 1'b1;
    data_wr_idx <= i;
    data_wr_src <= src;
    @(posedge clk);
    data_wr <= 1'b0;
  endtask : dwr

  task automatic drd(input logic [2:0] i, output logic [79:0] v);
    @(posedge clk);
    data_rd_idx <= i;
    @(posedge clk);
    #1 v = data_rd;
  endtask : drd

  task automatic t_user_clear(input string nm);
    for (int s = 0; s < 3; s++) begin
      rd(fpur_sel_e'(s), rv);
      check(nm, rv, 32'h0);
    end
  endtask : t_user_clear

  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      drd(i[2:0], dv);
      check("data after reset", dv, qnan);
    end
    t_user_clear("user after reset");
  endtask : t_reset

  task automatic t_control();
    logic [6:0] mb [4];
    mb = '{7'h40, 7'h18, 7'h35, 7'h40};
    wr(sel_control, 32'hffff_ffff);
    rd(sel_control, rv);
    check("control upper", rv, 32'h0000_ffff);
    check("trap enable", trap_enable, 8'hff);
    for (int i = 0; i < 4; i++) begin
      wr(sel_control, {24'h0, i[1:0], i[1:0], 4'h0});
      #1 check("round mode", round_mode, i[1:0]);
      check("round width", round_width, i[1:0]);
      check("mant bits", round_mant_bits, mb[i]);
    end
  endtask : t_control

  task automatic t_data();
    dwr(3'h2, {fmt_sgl, 80'hc040_0000});
    dwr(3'h5, {fmt_dbl, 80'h3ff0_0000_0000_0000});
    dwr(3'h7, {fmt_ext, 80'hc000_c000_0000_0000_0001});
    drd(3'h2, dv);
    check("single in", dv, {1'b0, 15'h0, 64'h0} | {1'b1, 15'h4000, 64'hc000_0000_0000_0000});
    drd(3'h5, dv);
    check("double in", dv, {1'b0, 15'h3fff, 64'h8000_0000_0000_0000});
    drd(3'h7, dv);
    check("extended in", dv, 80'hc000_c000_0000_0000_0001);
  endtask : t_data

  task automatic t_ops();
    wr(sel_control, 32'h0000_1000);
    iu.issue(kind_arith, 32'h0000_1234, {kind_arith, 4'h2, 1'b1, 8'h85, 8'h10}, 2);
    #1 check("trap raised", trap_req, 1'b1);
    rd(sel_status, rv);
    check("trap pulse", trap_req, 1'b0);
    check("status arith", rv, 32'h0285_1048);
    rd(sel_iaddr, rv);
    check("iaddr capture", rv, 32'h0000_1234);
    iu.issue(kind_multi_move, 32'h0000_5678, {kind_multi_move, 4'h1, 1'b0, 8'h11, 8'h50}, 0);
    #1 check("no trap multi", trap_req, 1'b0);
    rd(sel_status, rv);
    check("status multi", rv, 32'h0285_1048);
    rd(sel_iaddr, rv);
    check("iaddr kept", rv, 32'h0000_1234);
    iu.issue(kind_arith, 32'h0000_9abc, {kind_arith, 4'h8, 1'b0, 8'h00, 8'h68}, 5);
    #1 check("no trap masked", trap_req, 1'b0);
    rd(sel_status, rv);
    check("status combine", rv, 32'h0885_68c8);
    iu.issue(kind_move_in, 32'h0000_def0, {kind_move_in, 4'h0, 1'b0, 8'h00, 8'h02}, 1);
    rd(sel_status, rv);
    check("status move", rv, 32'h0885_02c8);
    rd(sel_iaddr, rv);
    check("iaddr move", rv, 32'h0000_def0);
  endtask : t_ops

  task automatic t_sticky();
    wr(sel_control, 32'h0000_ff00);
    wr(sel_status, 32'h0000_00f8);
    #1 check("no trap on write", trap_req, 1'b0);
    rd(sel_status, rv);
    check("accrued written", rv, 32'h0000_00f8);
    check("still no trap", trap_req, 1'b0);
    wr(sel_status, 32'h0000_0000);
    rd(sel_status, rv);
    check("accrued cleared", rv, 32'h0);
  endtask : t_sticky

  task automatic t_null();
    wr(sel_status, 32'h0fff_fff8);
    dwr(3'h2, {fmt_dbl, 80'h3ff0_0000_0000_0000});
    @(posedge clk);
    null_restore <= 1'b1;
    @(posedge clk);
    null_restore <= 1'b0;
    t_user_clear("user after restore");
    drd(3'h2, dv);
    check("data after restore", dv, qnan);
    check("enables after restore", trap_enable, 8'h00);
  endtask : t_null

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done();
  end

  initial begin
    fails = 0;
    n_tests = 0;
    rst_n = 1'b0;
    null_restore = 1'b0;
    user_wr = 1'b0;
    user_sel = sel_control;
    user_wdata = 32'h0;
    data_wr = 1'b0;
    data_wr_idx = 3'h0;
    data_wr_src = '0;
    data_rd_idx = 3'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_control();
    t_data();
    t_ops();
    t_sticky();
    t_null();
    test_done();
  end
endmodule : fpur_regs_bench
`default_nettype wire
